// [hdl/boc_pkg.sv]
/*
 * Constants for the button output configuration block: register offsets,
 * reset values, field positions, command codes and busy times.
 * Assumes a single 100 MHz clock.
 */
package boc_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          NUM_OUT    = 2;
   localparam logic [7:0] ADR_LEVEL  = 8'h04;
   localparam logic [7:0] ADR_SENSE  = 8'h07;
   localparam logic [7:0] ADR_OE     = 8'h08;
   localparam logic [7:0] ADR_STRONG = 8'h11;
   localparam logic [7:0] ADR_CFG [NUM_OUT] = '{8'h1c, 8'h21};
   localparam logic [7:0] ADR_SEL [NUM_OUT] = '{8'h1e, 8'h23};
   localparam logic [7:0] ADR_RPT    = 8'h90;
   localparam logic [7:0] ADR_CMD    = 8'ha0;

   // Reset values
   localparam logic [7:0] RST_LEVEL  = 8'h01;
   localparam logic [7:0] RST_SENSE  = 8'h01;
   localparam logic [7:0] RST_OE     = 8'h01;
   localparam logic [7:0] RST_STRONG = 8'h01;
   localparam logic [7:0] RST_CFG    = 8'h00;
   localparam logic [7:0] RST_SEL [NUM_OUT] = '{8'h01, 8'h02};
   localparam logic       RST_SCAN   = 1'b1;

   // Combiner config fields
   localparam int CFG_EN_BIT  = 7;
   localparam int CFG_INV_BIT = 1;
   localparam int CFG_AND_BIT = 0;

   // ****************************************************************
   // Commands and timing
   // ****************************************************************
   localparam logic [7:0] CMD_FWREV    = 8'h00;
   localparam logic [7:0] CMD_STORE    = 8'h01;
   localparam logic [7:0] CMD_FACTORY  = 8'h02;
   localparam logic [7:0] CMD_WRDEF    = 8'h03;
   localparam logic [7:0] CMD_RDDEF    = 8'h04;
   localparam logic [7:0] CMD_RDRAM    = 8'h05;
   localparam logic [7:0] CMD_RECONF   = 8'h06;
   localparam logic [7:0] CMD_NORMAL   = 8'h07;
   localparam logic [7:0] CMD_SETUP    = 8'h08;
   localparam logic [7:0] CMD_SCAN_ON  = 8'h09;
   localparam logic [7:0] CMD_SCAN_OFF = 8'h0a;
   localparam logic [7:0] CMD_SCAN_RPT = 8'h0b;

   localparam int CLK_MHZ    = 100;
   localparam int T_LONG_MS  = 120;
   localparam int T_MID_MS   = 10;
   localparam int T_SHORT_MS = 5;
   localparam int CYC_LONG   = T_LONG_MS * 1000 * CLK_MHZ;
   localparam int CYC_MID    = T_MID_MS * 1000 * CLK_MHZ;
   localparam int CYC_SHORT  = T_SHORT_MS * 1000 * CLK_MHZ;

   typedef enum logic {BOC_NORMAL, BOC_SETUP} boc_mode_t;
endpackage : boc_pkg

// [hdl/boc_cmd_if.sv]
/*
 * Carrier between the register front end and the command executor.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ns
interface boc_cmd_if import boc_pkg::*; ();
   logic       stb;     // Command register written
   logic [7:0] code;    // Command code
   boc_mode_t  mode;    // Current mode
   logic       scan;    // Scanning enabled
   logic       busy;    // Device inaccessible
   logic       nvm_stb; // Storage request pulse
   logic [2:0] nvm_op;  // Storage operation code
   logic [7:0] rpt;     // Report value

   modport ctl (output stb, code,
                input  mode, scan, busy, nvm_stb, nvm_op, rpt);
   modport exe (input  stb, code,
                output mode, scan, busy, nvm_stb, nvm_op, rpt);
endinterface : boc_cmd_if

// [hdl/boc_comb.sv]
/*
 * One output's OR/AND combiner over selected button states.
 * Assumes button states are synchronous levels.
 */
`timescale 1ns/1ns
module boc_comb (
   input  wire logic       use_and, // 1: AND, 0: OR
   input  wire logic       inv,     // Invert result
   input  wire logic [1:0] sel,     // Selected buttons
   input  wire logic [1:0] btn,     // Button states
   output wire logic       res      // Combined result
);
   // Unselected inputs are neutral for either operator
   wire logic any_hit = |(sel & btn);
   wire logic all_hit = &(btn | ~sel);
   assign res = (use_and ? all_hit : any_hit) ^ inv;
endmodule : boc_comb

// [hdl/boc_cmd.sv]
/*
 * Command executor: mode, scan state, storage requests, busy timer.
 * Assumes the front end never strobes while busy is high.
 */
`timescale 1ns/1ns
module boc_cmd import boc_pkg::*; #(
   parameter logic [23:0] LONG_CYC  = 24'(CYC_LONG),
   parameter logic [23:0] MID_CYC   = 24'(CYC_MID),
   parameter logic [23:0] SHORT_CYC = 24'(CYC_SHORT),
   parameter logic [7:0]  FW_REV    = 8'h5a // Arbitrary value
) (
   input  wire logic mclk, // Clock
   input  wire logic rst,  // Async reset
   boc_cmd_if.exe    cif   // Command carrier
);
   // ****************************************************************
   // Decode
   // ****************************************************************
   logic [23:0] cnt_q;
   wire  logic [7:0]  c       = cif.code;
   wire  logic        is_long = c inside {CMD_STORE, CMD_FACTORY,
                                          CMD_WRDEF};
   wire  logic        is_mid  = c == CMD_SCAN_ON;
   wire  logic        is_shrt = c inside {CMD_RDDEF, CMD_RDRAM,
                                          CMD_RECONF, CMD_SCAN_OFF};
   // Reconfigure is refused outside setup mode
   wire  logic        take    = cif.stb && c <= CMD_SCAN_RPT &&
                        !(c == CMD_RECONF && cif.mode != BOC_SETUP);
   wire  logic [23:0] dly     = is_long ? LONG_CYC : is_mid ? MID_CYC :
                                is_shrt ? SHORT_CYC : 24'h0;
   wire  logic [23:0] cnt_d   = take ? dly :
                     (cnt_q != 24'h0) ? cnt_q - 24'h1 : cnt_q;

   // Busy timer counts the whole inaccessible time
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q    <= 24'h0;
         cif.busy <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         cif.busy <= cnt_d != 24'h0;
      end
   end

   // Mode, scan, storage pulse and report
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cif.mode    <= BOC_NORMAL;
         cif.scan    <= RST_SCAN;
         cif.nvm_stb <= 1'b0;
         cif.nvm_op  <= 3'h0;
         cif.rpt     <= 8'h00;
      end else begin
         cif.nvm_stb <= take && c >= CMD_STORE && c <= CMD_RECONF;
         if (take) begin
            cif.nvm_op <= c[2:0];
            if (c == CMD_NORMAL) cif.mode <= BOC_NORMAL;
            if (c == CMD_SETUP) cif.mode <= BOC_SETUP;
            if (c == CMD_SCAN_ON) cif.scan <= 1'b1;
            if (c == CMD_SCAN_OFF) cif.scan <= 1'b0;
            if (c == CMD_SCAN_RPT) cif.rpt <= {7'h0, cif.scan};
            if (c == CMD_FWREV) cif.rpt <= FW_REV;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   AST_STORE_BUSY: assert property (
      take && c == CMD_STORE |=> cif.busy && cnt_q == LONG_CYC)
      else $error("store did not start long busy");
   AST_WRDEF_BUSY: assert property (
      take && c == CMD_WRDEF |=> cif.busy ##1 cnt_q == LONG_CYC - 1)
      else $error("write defaults busy wrong");
   AST_RDDEF_BUSY: assert property (
      take && c == CMD_RDDEF |=> cnt_q == SHORT_CYC && cif.nvm_op == 3'h4)
      else $error("load defaults busy wrong");
   AST_RDRAM_BUSY: assert property (
      take && c == CMD_RDRAM |=> cnt_q == SHORT_CYC && cif.nvm_stb)
      else $error("read ram busy wrong");
   AST_NORMAL_NOW: assert property (
      take && c == CMD_NORMAL && !cif.busy
      |=> cif.mode == BOC_NORMAL && !cif.busy)
      else $error("normal mode not immediate");
   AST_SETUP_NOW: assert property (
      take && c == CMD_SETUP && !cif.busy
      |=> cif.mode == BOC_SETUP && !cif.busy)
      else $error("setup mode not immediate");
   AST_SCAN_RPT: assert property (
      take && c == CMD_SCAN_RPT
      |=> cif.rpt[0] == $past(cif.scan) && !cif.busy)
      else $error("scan report wrong");
   AST_BUSY_END: assert property (
      cnt_q == 24'h1 && !cif.stb |=> !cif.busy)
      else $error("busy outlived its count");
   CV_STORE: cover property (take && c == CMD_STORE);
endmodule : boc_cmd

// [hdl/boc_top.sv]
/*
 * Button output configuration block: register port, command handling,
 * output level/enable/drive and per-output OR/AND combiner.
 * Assumes register port and button states are synchronous to mclk.
 */
`timescale 1ns/1ns
module boc_top import boc_pkg::*; #(
   parameter logic [23:0] LONG_CYC  = 24'(CYC_LONG),
   parameter logic [23:0] MID_CYC   = 24'(CYC_MID),
   parameter logic [23:0] SHORT_CYC = 24'(CYC_SHORT)
) (
   input  wire logic       mclk,              // Clock
   input  wire logic       rst,               // Async reset
   input  wire logic       reg_wr,            // Write strobe
   input  wire logic       reg_rd,            // Read strobe
   input  wire logic [7:0] reg_addr,          // Register offset
   input  wire logic [7:0] reg_wdata,         // Write data
   input  wire logic [1:0] btn_touch,         // Button states
   output wire logic [7:0] reg_rdata,         // Read data
   output wire logic       reg_rvalid,        // Read data valid
   output wire logic       dev_busy,          // Inaccessible
   output wire logic       setup_mode,        // Setup mode
   output wire logic       scan_enable,       // Scanning on
   output wire logic [1:0] sense_enable,      // Input enables
   output wire logic [1:0] output_pin_bits,   // Pin levels
   output wire logic [1:0] output_pin_oe_n,   // Pin drive, low on
   output wire logic [1:0] strong_drive_bits, // Strong drive
   output wire logic       nvm_req,           // Storage request
   output wire logic [2:0] nvm_op             // Storage operation
);
   // ****************************************************************
   // Register port front end
   // ****************************************************************
   boc_cmd_if cif ();

   logic [1:0]            level_q, sense_q, oe_q, strong_q;
   logic [1:0]            cfg_en_q, cfg_inv_q, cfg_and_q;
   logic [NUM_OUT-1:0][1:0] sel_q;
   logic [1:0]            pin_q, oe_n_q, drv_q;
   logic [7:0]            rdata_q;
   logic                  rvalid_q;

   // Port is deaf while busy; host is expected to wait anyway
   wire logic wr_ok    = reg_wr && !cif.busy;
   wire logic rd_ok    = reg_rd && !cif.busy;
   wire logic is_setup = cif.mode == BOC_SETUP;

   function automatic logic hit(input logic       ok,
                                input logic [7:0] adr,
                                input logic [7:0] a);
      return ok && (adr == a);
   endfunction : hit

   // Command strobe into the executor
   assign cif.stb  = hit(wr_ok, reg_addr, ADR_CMD);
   assign cif.code = reg_wdata;

   // Protected writes need setup mode
   wire logic wr_sense  = hit(wr_ok, reg_addr, ADR_SENSE) && is_setup;
   wire logic wr_oe     = hit(wr_ok, reg_addr, ADR_OE) && is_setup;
   wire logic wr_strong = hit(wr_ok, reg_addr, ADR_STRONG) && is_setup;
   wire logic wr_level  = hit(wr_ok, reg_addr, ADR_LEVEL);

   wire logic [1:0] sense_d  = wr_sense ? reg_wdata[1:0] : sense_q;
   wire logic [1:0] oe_d     = wr_oe ? reg_wdata[1:0] : oe_q;
   wire logic [1:0] strong_d = wr_strong ? reg_wdata[1:0] : strong_q;

   // ****************************************************************
   // Per-output registers and combiners
   // ****************************************************************
   logic [1:0]              level_d, cfg_en_d, cfg_inv_d, cfg_and_d;
   logic [1:0]              res, pin_d;
   logic [NUM_OUT-1:0][1:0] sel_d;
   logic [NUM_OUT-1:0][7:0] cfg_rd, sel_rd;
   logic [NUM_OUT-1:0]      cfg_hit, sel_hit;

   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      // Config writes count only on an enabled output
      wire logic wr_cfg = hit(wr_ok, reg_addr, ADR_CFG[i]) && oe_q[i];
      wire logic wr_sel = hit(wr_ok, reg_addr, ADR_SEL[i]);

      // Combiner-driven pins keep their level bit untouched
      assign level_d[i] = (wr_level && !cfg_en_q[i]) ?
                          reg_wdata[i] : level_q[i];
      assign cfg_en_d[i]  = wr_cfg ? reg_wdata[CFG_EN_BIT] :
                            cfg_en_q[i];
      assign cfg_inv_d[i] = wr_cfg ? reg_wdata[CFG_INV_BIT] :
                            cfg_inv_q[i];
      assign cfg_and_d[i] = wr_cfg ? reg_wdata[CFG_AND_BIT] :
                            cfg_and_q[i];
      assign sel_d[i]     = wr_sel ? reg_wdata[1:0] : sel_q[i];

      boc_comb u_comb (
         .use_and (cfg_and_q[i]),
         .inv     (cfg_inv_q[i]),
         .sel     (sel_q[i]),
         .btn     (btn_touch),
         .res     (res[i])
      );

      // Pin source: combiner or level register
      assign pin_d[i] = cfg_en_q[i] ? res[i] : level_q[i];

      // Readback views
      assign cfg_rd[i]  = {cfg_en_q[i], 5'h00, cfg_inv_q[i],
                           cfg_and_q[i]};
      assign sel_rd[i]  = {6'h00, sel_q[i]};
      assign cfg_hit[i] = reg_addr == ADR_CFG[i];
      assign sel_hit[i] = reg_addr == ADR_SEL[i];
   end

   // Configuration storage
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         level_q   <= RST_LEVEL[1:0];
         sense_q   <= RST_SENSE[1:0];
         oe_q      <= RST_OE[1:0];
         strong_q  <= RST_STRONG[1:0];
         cfg_en_q  <= {2{RST_CFG[CFG_EN_BIT]}};
         cfg_inv_q <= {2{RST_CFG[CFG_INV_BIT]}};
         cfg_and_q <= {2{RST_CFG[CFG_AND_BIT]}};
         sel_q     <= {RST_SEL[1][1:0], RST_SEL[0][1:0]};
      end else begin
         level_q   <= level_d;
         sense_q   <= sense_d;
         oe_q      <= oe_d;
         strong_q  <= strong_d;
         cfg_en_q  <= cfg_en_d;
         cfg_inv_q <= cfg_inv_d;
         cfg_and_q <= cfg_and_d;
         sel_q     <= sel_d;
      end
   end

   // ****************************************************************
   // Pins and readback
   // ****************************************************************
   // Strong drive only counts on an enabled pin
   wire logic [1:0] drv_d = oe_q & strong_q;

   // Level register is write-only and reads as zero
   wire logic [7:0] rd_mux =
      (reg_addr == ADR_SENSE)  ? {6'h00, sense_q}  :
      (reg_addr == ADR_OE)     ? {6'h00, oe_q}     :
      (reg_addr == ADR_STRONG) ? {6'h00, strong_q} :
      cfg_hit[0]               ? cfg_rd[0]         :
      cfg_hit[1]               ? cfg_rd[1]         :
      sel_hit[0]               ? sel_rd[0]         :
      sel_hit[1]               ? sel_rd[1]         :
      (reg_addr == ADR_RPT)    ? cif.rpt           : 8'h00;

   // Outputs are registered so pins never glitch on decode
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_q    <= 2'h0;
         oe_n_q   <= 2'h3;
         drv_q    <= 2'h0;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         pin_q    <= pin_d;
         oe_n_q   <= ~oe_q;
         drv_q    <= drv_d;
         rdata_q  <= rd_ok ? rd_mux : 8'h00;
         rvalid_q <= rd_ok;
      end
   end

   boc_cmd #(
      .LONG_CYC  (LONG_CYC),
      .MID_CYC   (MID_CYC),
      .SHORT_CYC (SHORT_CYC)
   ) u_cmd (
      .mclk (mclk),
      .rst  (rst),
      .cif  (cif)
   );

   assign reg_rdata         = rdata_q;
   assign reg_rvalid        = rvalid_q;
   assign dev_busy          = cif.busy;
   assign setup_mode        = is_setup;
   assign scan_enable       = cif.scan;
   assign sense_enable      = sense_q;
   assign output_pin_bits   = pin_q;
   assign output_pin_oe_n   = oe_n_q;
   assign strong_drive_bits = drv_q;
   assign nvm_req           = cif.nvm_stb;
   assign nvm_op            = cif.nvm_op;

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Independent models of both combiners
   wire logic exp1 = (cfg_and_q[1] ? &(btn_touch | ~sel_q[1]) :
                      |(btn_touch & sel_q[1])) ^ cfg_inv_q[1];
   wire logic exp0 = (cfg_and_q[0] ? &(btn_touch | ~sel_q[0]) :
                      |(btn_touch & sel_q[0])) ^ cfg_inv_q[0];

   AST_LEVEL_MASK: assert property (@(posedge mclk) disable iff (rst)
      wr_level && cfg_en_q[0] ##1 cfg_en_q[0]
      |=> output_pin_bits[0] == $past(res[0]))
      else $error("level write reached combiner pin");
   AST_LEVEL_PIN: assert property (@(posedge mclk) disable iff (rst)
      wr_level && !cfg_en_q[1] ##1 !cfg_en_q[1]
      |=> output_pin_bits[1] == $past(reg_wdata[1], 2))
      else $error("pin did not take level");
   AST_COMB_PIN: assert property (@(posedge mclk) disable iff (rst)
      cfg_en_q[1] |=> output_pin_bits[1] == $past(exp1))
      else $error("combiner output wrong");
   AST_SENSE_LOCK: assert property (@(posedge mclk) disable iff (rst)
      hit(wr_ok, reg_addr, ADR_SENSE) && !is_setup |=> $stable(sense_q))
      else $error("sense enable written outside setup");
   AST_SENSE_SET: assert property (@(posedge mclk) disable iff (rst)
      wr_sense |=> sense_enable == $past(reg_wdata[1:0]))
      else $error("sense enable not written");
   AST_OE_PIN: assert property (@(posedge mclk) disable iff (rst)
      wr_oe |=> ##1 output_pin_oe_n == ~$past(reg_wdata[1:0], 2))
      else $error("output enable not on pin");
   AST_STRONG: assert property (@(posedge mclk) disable iff (rst)
      !oe_q[0] |=> !strong_drive_bits[0])
      else $error("strong drive on disabled pin");
   AST_CFG_IGNORE: assert property (@(posedge mclk) disable iff (rst)
      hit(wr_ok, reg_addr, ADR_CFG[1]) && !oe_q[1]
      |=> $stable(cfg_en_q[1]) && $stable(cfg_and_q[1]))
      else $error("config written on disabled pin");
   AST_BUSY_DEAF: assert property (@(posedge mclk) disable iff (rst)
      dev_busy && reg_rd |=> !reg_rvalid)
      else $error("read answered while busy");

   // Level bits under a combiner must survive a level write
   AST_LVL_KEPT: assert property (@(posedge mclk) disable iff (rst)
      wr_level
      |=> ((level_q ^ $past(level_q)) & $past(cfg_en_q)) == 2'h0)
      else $error("level write changed combiner output");
   AST_LVL_READ: assert property (@(posedge mclk) disable iff (rst)
      rd_ok && reg_addr == ADR_LEVEL
      |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("write-only level register read back");

   // Drive settings reach the pins one edge after storage
   AST_OE_HIZ: assert property (@(posedge mclk) disable iff (rst)
      !oe_q[1] |=> output_pin_oe_n[1])
      else $error("disabled output still driven");
   AST_OE_DRV: assert property (@(posedge mclk) disable iff (rst)
      oe_q[0] |=> !output_pin_oe_n[0])
      else $error("enabled output not driven");
   AST_STRONG_ON: assert property (@(posedge mclk) disable iff (rst)
      oe_q[1] && strong_q[1] |=> strong_drive_bits[1])
      else $error("strong drive missing on enabled pin");

   // Combiner configuration and input selection
   AST_COMB0: assert property (@(posedge mclk) disable iff (rst)
      cfg_en_q[0] |=> output_pin_bits[0] == $past(exp0))
      else $error("output 0 not fed by its combiner");
   AST_CFG_EN: assert property (@(posedge mclk) disable iff (rst)
      hit(wr_ok, reg_addr, ADR_CFG[0]) && oe_q[0]
      |=> cfg_en_q[0] == $past(reg_wdata[CFG_EN_BIT]))
      else $error("combiner enable not written");
   AST_CFG_INV: assert property (@(posedge mclk) disable iff (rst)
      hit(wr_ok, reg_addr, ADR_CFG[1]) && oe_q[1]
      |=> cfg_inv_q[1] == $past(reg_wdata[CFG_INV_BIT]) &&
          cfg_and_q[1] == $past(reg_wdata[CFG_AND_BIT]))
      else $error("combiner invert or operator not written");
   AST_CFG0_KEEP: assert property (@(posedge mclk) disable iff (rst)
      hit(wr_ok, reg_addr, ADR_CFG[0]) && !oe_q[0]
      |=> $stable(cfg_en_q[0]) && $stable(cfg_inv_q[0]))
      else $error("config 0 written on disabled pin");
   AST_SEL_WR: assert property (@(posedge mclk) disable iff (rst)
      hit(wr_ok, reg_addr, ADR_SEL[1])
      |=> sel_q[1] == $past(reg_wdata[1:0]))
      else $error("input select not written");
   AST_PIN_LVL: assert property (@(posedge mclk) disable iff (rst)
      !cfg_en_q[0] |=> output_pin_bits[0] == $past(level_q[0]))
      else $error("pin did not follow level register");

   CV_COMB_AND: cover property (@(posedge mclk) disable iff (rst)
      cfg_en_q[1] && cfg_and_q[1] && exp1);
   CV_SETUP_WR: cover property (@(posedge mclk) disable iff (rst)
      wr_sense ##1 wr_oe);
   CV_BUSY_RD: cover property (@(posedge mclk) disable iff (rst)
      dev_busy && reg_rd);
   CV_LVL_KEPT: cover property (@(posedge mclk) disable iff (rst)
      wr_level && cfg_en_q[0]);
endmodule : boc_top

// [verif/boc_host.sv]
/* Host model on the register port of the button output block.
   Assumes dev_busy and the read answer are registered on mclk. */
`timescale 1ns/1ns
module boc_host (
   input  wire logic       mclk,       // Clock
   input  wire logic       dev_busy,   // Device inaccessible
   input  wire logic [7:0] reg_rdata,  // Read data
   input  wire logic       reg_rvalid, // Read valid
   output logic            reg_wr,     // Write strobe
   output logic            reg_rd,     // Read strobe
   output logic [7:0]      reg_addr,   // Offset
   output logic [7:0]      reg_wdata   // Write data
);
   // Port idle at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end
   // Stay off the port while busy, for at most 64 falling edges; check on the falling edge to avoid races
   task automatic idle_wait();
      @(negedge mclk);
      for (int i = 0; i < 64 && dev_busy !== 1'b0; i++) @(negedge mclk);
   endtask : idle_wait
   // One write; returns at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      idle_wait();
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // One read; answer sampled 1 ns after the edge that takes it
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      idle_wait();
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
      v = reg_rvalid;
   endtask : rd
endmodule : boc_host

// [verif/button_output_config_tb.sv]
/* Self-checking bench for the button output block.
   Assumes boc_pkg and the short busy counts set below. */
`timescale 1ns/1ns
module button_output_config_tb import boc_pkg::*;;
   localparam int LC = 20;
   localparam int MC = 10;
   localparam int SC = 5;
   logic       mclk, rst, reg_wr, reg_rd, reg_rvalid, dev_busy, setup_mode;
   logic       scan_enable, nvm_req, v;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, c;
   logic [1:0] btn_touch, sense_enable, output_pin_bits, output_pin_oe_n;
   logic [1:0] strong_drive_bits, lvl;
   logic [2:0] nvm_op;
   logic [31:0] rnd;
   logic [7:0] cfg [2];
   logic [1:0] sel [2];
   int         num_errors, cmp_count, n;
   logic [7:0] ta [7] = '{8'h07, 8'h08, 8'h11, 8'h1c, 8'h21, 8'h04, 8'h33};
   logic [7:0] te [7] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] cc [10] = '{CMD_STORE, CMD_WRDEF, CMD_RDDEF, CMD_RDRAM,
                           CMD_NORMAL, CMD_SETUP, CMD_RECONF, CMD_SCAN_OFF,
                           CMD_SCAN_RPT, CMD_SCAN_ON};
   int         cy [10] = '{LC, LC, SC, SC, 0, 0, SC, SC, 0, MC};
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
   // ****************************************************************
   // Design, host model, clock
   // ****************************************************************
   boc_top #(.LONG_CYC(24'(LC)), .MID_CYC(24'(MC)), .SHORT_CYC(24'(SC)))
   dut_u (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .btn_touch,
      .reg_rdata, .reg_rvalid, .dev_busy, .setup_mode, .scan_enable,
      .sense_enable, .output_pin_bits, .output_pin_oe_n,
      .strong_drive_bits, .nvm_req, .nvm_op);
   boc_host host_u (.mclk, .dev_busy, .reg_rdata, .reg_rvalid, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Empty select gives OR 0 and AND 1, as the note chose
   function automatic logic pin_f(logic [7:0] f, logic [1:0] s,
                                  logic [1:0] b, logic l);
      logic r;
      r = f[0] ? &(b | ~s) : |(b & s);
      return f[7] ? r ^ f[1] : l;
   endfunction : pin_f
   task automatic end_sim();
      $display("Counts: errors %0d checks %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // Watchdog: whole run is a few hundred cycles
   initial begin
      #500000;
      num_errors++;
      end_sim();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst = 1'b1;
      btn_touch = 2'b00;
      rnd = 32'd82307;
      lvl = 2'b01;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK("rst outs", 12'h655, {output_pin_bits, output_pin_oe_n, strong_drive_bits, sense_enable, setup_mode, scan_enable, dev_busy, 1'b1})
      // Reset values, write-only level and an unmapped place read as 0
      for (int i = 0; i < 7; i++) begin
         host_u.rd(ta[i], d, v);
         `CHK("rd reset", {1'b1, te[i]}, {v, d})
      end
      // Setup-only registers refuse writes in normal mode
      host_u.wr(ADR_SENSE, 8'h02);
      host_u.rd(ADR_SENSE, d, v);
      `CHK("sense normal", 8'h01, d)
      host_u.wr(ADR_CMD, CMD_SETUP);
      host_u.wr(ADR_SENSE, 8'h02); // Sense enables first
      host_u.wr(ADR_OE, 8'h03);
      host_u.wr(ADR_STRONG, 8'h03); // Strong drive with every enable
      repeat (2) @(posedge mclk);
      #1;
      `CHK("drive", 6'h23, {sense_enable, output_pin_oe_n, strong_drive_bits})
      // Random combiner settings, buttons and level writes
      for (int k = 0; k < 12; k++) begin
         for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            cfg[i] = {rnd[0], 5'h00, rnd[2:1]};
            sel[i] = rnd[4:3];
            host_u.wr(ADR_CFG[i], cfg[i]);
            host_u.wr(ADR_SEL[i], {6'h00, sel[i]});
         end
         rnd = lfsr(rnd);
         host_u.wr(ADR_LEVEL, rnd[7:0]);
         for (int i = 0; i < 2; i++) if (!cfg[i][7]) lvl[i] = rnd[i];
         btn_touch <= rnd[9:8];
         repeat (2) @(posedge mclk);
         #1;
         for (int i = 0; i < 2; i++)
            `CHK("pin", pin_f(cfg[i], sel[i], rnd[9:8], lvl[i]), output_pin_bits[i])
      end
      // Config write to a disabled output is dropped
      host_u.wr(ADR_OE, 8'h01);
      host_u.wr(ADR_CFG[1], ~cfg[1] & 8'h83);
      host_u.wr(ADR_OE, 8'h03);
      host_u.rd(ADR_CFG[1], d, v);
      `CHK("cfg1 kept", cfg[1], d)
      // Command codes: storage request, mode and busy time
      for (int j = 0; j < 10; j++) begin
         c = cc[j];
         host_u.wr(ADR_CMD, c);
         #1;
         `CHK("nvm_req", logic'(c >= 8'h01 && c <= 8'h06), nvm_req)
         if (nvm_req === 1'b1) `CHK("nvm_op", c[2:0], nvm_op)
         n = 0;
         while (dev_busy === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
         end
         `CHK("busy", cy[j], n)
         if (c == CMD_NORMAL) `CHK("normal", 1'b0, setup_mode)
         if (c == CMD_SETUP) `CHK("setup", 1'b1, setup_mode)
      end
      host_u.rd(ADR_RPT, d, v);
      `CHK("scan rpt", 9'h100, {v, d})
      end_sim();
   end
endmodule : button_output_config_tb
